// File: rtl/iprfs_regs.sv
// Operation
// - Field code 00 disables the source, 01 gives level 0, 10 level 1, 11 level 2.
// - No field value maps a governed source above level 2.
// - Every priority field resets to the disabled code.
// - Reserved bits read as zero and ignore writes.
// - Register 4 holds serial port 0 rx-full at 15:14, port 1 tx-empty at 13:12, port 1 rx-full at 11:10.
// - Register 4 reserves 9:6 and holds pin ports A, B, C at 5:4, 3:2, 1:0.
// - Register 5 holds decoder 1 index 15:14, decoder 1 home 13:12, async 1 rx-full 11:10, rx-error 9:8.
// - Register 5 reserves 7:6 and holds async 1 tx-idle 5:4, tx-empty 3:2, serial port 0 tx-empty 1:0.
// - Register 6 holds timer C ch0 at 15:14 and timer D ch3..ch0 at 13:12, 11:10, 9:8, 7:6.
// - Register 6 reserves 5:4 and holds decoder 0 index at 3:2 and decoder 0 home at 1:0.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
module iprfs_regs
  import iprfs_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Raw requests, register 4 sources
  input  wire logic              serialPort0RxFullReq,
  input  wire logic              serialPort1TxEmptyReq,
  input  wire logic              serialPort1RxFullReq,
  input  wire logic              pinPortAReq,
  input  wire logic              pinPortBReq,
  input  wire logic              pinPortCReq,
  // Raw requests, register 5 sources
  input  wire logic              decoder1IndexReq,
  input  wire logic              decoder1HomeWatchdogReq,
  input  wire logic              asyncIf1RxFullReq,
  input  wire logic              asyncIf1RxErrorReq,
  input  wire logic              asyncIf1TxIdleReq,
  input  wire logic              asyncIf1TxEmptyReq,
  input  wire logic              serialPort0TxEmptyReq,
  // Raw requests, register 6 sources
  input  wire logic              timerCCh0Req,
  input  wire logic              timerDCh3Req,
  input  wire logic              timerDCh2Req,
  input  wire logic              timerDCh1Req,
  input  wire logic              timerDCh0Req,
  input  wire logic              decoder0IndexReq,
  input  wire logic              decoder0HomeWatchdogReq,
  // Forwarded requests to arbitration
  output logic                   serialPort0RxFullIrq,
  output logic                   serialPort1TxEmptyIrq,
  output logic                   serialPort1RxFullIrq,
  output logic                   pinPortAIrq,
  output logic                   pinPortBIrq,
  output logic                   pinPortCIrq,
  output logic                   decoder1IndexIrq,
  output logic                   decoder1HomeWatchdogIrq,
  output logic                   asyncIf1RxFullIrq,
  output logic                   asyncIf1RxErrorIrq,
  output logic                   asyncIf1TxIdleIrq,
  output logic                   asyncIf1TxEmptyIrq,
  output logic                   serialPort0TxEmptyIrq,
  output logic                   timerCCh0Irq,
  output logic                   timerDCh3Irq,
  output logic                   timerDCh2Irq,
  output logic                   timerDCh1Irq,
  output logic                   timerDCh0Irq,
  output logic                   decoder0IndexIrq,
  output logic                   decoder0HomeWatchdogIrq,
  // Priority level of each forwarded request
  output logic [1:0]             serialPort0RxFullLevel,
  output logic [1:0]             serialPort1TxEmptyLevel,
  output logic [1:0]             serialPort1RxFullLevel,
  output logic [1:0]             pinPortALevel,
  output logic [1:0]             pinPortBLevel,
  output logic [1:0]             pinPortCLevel,
  output logic [1:0]             decoder1IndexLevel,
  output logic [1:0]             decoder1HomeWatchdogLevel,
  output logic [1:0]             asyncIf1RxFullLevel,
  output logic [1:0]             asyncIf1RxErrorLevel,
  output logic [1:0]             asyncIf1TxIdleLevel,
  output logic [1:0]             asyncIf1TxEmptyLevel,
  output logic [1:0]             serialPort0TxEmptyLevel,
  output logic [1:0]             timerCCh0Level,
  output logic [1:0]             timerDCh3Level,
  output logic [1:0]             timerDCh2Level,
  output logic [1:0]             timerDCh1Level,
  output logic [1:0]             timerDCh0Level,
  output logic [1:0]             decoder0IndexLevel,
  output logic [1:0]             decoder0HomeWatchdogLevel
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [REG_W-1:0]   prio_q   [NUM_REGS];
  logic [REG_W-1:0]   prio_d   [NUM_REGS];
  logic [REG_W-1:0]   regMask  [NUM_REGS];
  logic [NUM_REGS-1:0] regHit;
  logic               pendHit;
  logic               anyHit;
  logic               setupPhase;
  logic               accessPhase;
  logic               wrEn;
  logic [DATA_W-1:0]  rdMux;
  logic [DATA_W-1:0]  prdata_q;
  logic [DATA_W-1:0]  prdata_d;
  logic               slvErr_q;
  logic               slvErr_d;
  logic [NUM_SRC-1:0] srcReq;
  logic [NUM_SRC-1:0] irqReq;
  logic [1:0]         irqLevel [NUM_SRC];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign regMask[0]  = MASK_PRIO4;
  assign regMask[1]  = MASK_PRIO5;
  assign regMask[2]  = MASK_PRIO6;

  assign regHit[0]   = (paddr == regByteAddr(IDX_PRIO4));
  assign regHit[1]   = (paddr == regByteAddr(IDX_PRIO5));
  assign regHit[2]   = (paddr == regByteAddr(IDX_PRIO6));
  assign pendHit     = (paddr == regByteAddr(IDX_PENDING));
  assign anyHit      = (|regHit) | pendHit;

  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  // Zero wait states; read data and error are latched in the setup cycle
  assign pready      = 1'b1;
  assign wrEn        = accessPhase & pwrite & ~slvErr_q;

  assign rdMux = regHit[0] ? {{(DATA_W-REG_W){1'b0}}, prio_q[0]} :
                 regHit[1] ? {{(DATA_W-REG_W){1'b0}}, prio_q[1]} :
                 regHit[2] ? {{(DATA_W-REG_W){1'b0}}, prio_q[2]} :
                 pendHit   ? {{(DATA_W-NUM_SRC){1'b0}}, irqReq}   :
                             {DATA_W{1'b0}};

  // Pending view is read-only: a write there is dropped without error
  assign prdata_d = setupPhase ? (pwrite ? {DATA_W{1'b0}} : rdMux) : prdata_q;
  assign slvErr_d = setupPhase ? ~anyHit : (accessPhase ? slvErr_q : 1'b0);

  assign prdata   = prdata_q;
  assign pslverr  = accessPhase & slvErr_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= {DATA_W{1'b0}};
      slvErr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      slvErr_q <= slvErr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority registers

  for (genvar k = 0; k < NUM_REGS; k++) begin : g_reg
    // Masked merge keeps reserved ranges at zero whatever is written
    assign prio_d[k] = (wrEn && regHit[k]) ?
                       writeMerge(prio_q[k], pwdata[REG_W-1:0], pstrb[1:0], regMask[k]) :
                       prio_q[k];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NUM_REGS; k++) begin
        prio_q[k] <= RESET_PRIO;
      end
    end else begin
      for (int k = 0; k < NUM_REGS; k++) begin
        prio_q[k] <= prio_d[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source gating

  assign srcReq = {decoder0HomeWatchdogReq, decoder0IndexReq,
                   timerDCh0Req, timerDCh1Req, timerDCh2Req, timerDCh3Req, timerCCh0Req,
                   serialPort0TxEmptyReq, asyncIf1TxEmptyReq, asyncIf1TxIdleReq,
                   asyncIf1RxErrorReq, asyncIf1RxFullReq, decoder1HomeWatchdogReq, decoder1IndexReq,
                   pinPortCReq, pinPortBReq, pinPortAReq,
                   serialPort1RxFullReq, serialPort1TxEmptyReq, serialPort0RxFullReq};

  // Field placement comes from the per-source slot and lsb tables
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    iprfs_src_gate u_gate (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .fieldCode  (prio_q[SRC_REG[i]][SRC_LSB[i] +: 2]),
      .srcReq     (srcReq[i]),
      .irqReq_q   (irqReq[i]),
      .irqLevel_q (irqLevel[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output fan-out

  assign serialPort0RxFullIrq      = irqReq[0];
  assign serialPort1TxEmptyIrq     = irqReq[1];
  assign serialPort1RxFullIrq      = irqReq[2];
  assign pinPortAIrq               = irqReq[3];
  assign pinPortBIrq               = irqReq[4];
  assign pinPortCIrq               = irqReq[5];
  assign decoder1IndexIrq          = irqReq[6];
  assign decoder1HomeWatchdogIrq   = irqReq[7];
  assign asyncIf1RxFullIrq         = irqReq[8];
  assign asyncIf1RxErrorIrq        = irqReq[9];
  assign asyncIf1TxIdleIrq         = irqReq[10];
  assign asyncIf1TxEmptyIrq        = irqReq[11];
  assign serialPort0TxEmptyIrq     = irqReq[12];
  assign timerCCh0Irq              = irqReq[13];
  assign timerDCh3Irq              = irqReq[14];
  assign timerDCh2Irq              = irqReq[15];
  assign timerDCh1Irq              = irqReq[16];
  assign timerDCh0Irq              = irqReq[17];
  assign decoder0IndexIrq          = irqReq[18];
  assign decoder0HomeWatchdogIrq   = irqReq[19];

  assign serialPort0RxFullLevel    = irqLevel[0];
  assign serialPort1TxEmptyLevel   = irqLevel[1];
  assign serialPort1RxFullLevel    = irqLevel[2];
  assign pinPortALevel             = irqLevel[3];
  assign pinPortBLevel             = irqLevel[4];
  assign pinPortCLevel             = irqLevel[5];
  assign decoder1IndexLevel        = irqLevel[6];
  assign decoder1HomeWatchdogLevel = irqLevel[7];
  assign asyncIf1RxFullLevel       = irqLevel[8];
  assign asyncIf1RxErrorLevel      = irqLevel[9];
  assign asyncIf1TxIdleLevel       = irqLevel[10];
  assign asyncIf1TxEmptyLevel      = irqLevel[11];
  assign serialPort0TxEmptyLevel   = irqLevel[12];
  assign timerCCh0Level            = irqLevel[13];
  assign timerDCh3Level            = irqLevel[14];
  assign timerDCh2Level            = irqLevel[15];
  assign timerDCh1Level            = irqLevel[16];
  assign timerDCh0Level            = irqLevel[17];
  assign decoder0IndexLevel        = irqLevel[18];
  assign decoder0HomeWatchdogLevel = irqLevel[19];

endmodule : iprfs_regs

// File: rtl/iprfs_pkg.sv
package iprfs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 16;
  localparam int          NUM_REGS    = 3;
  localparam int          NUM_SRC     = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_PRIO4   = 10'h004;
  localparam logic [9:0]  IDX_PRIO5   = 10'h005;
  localparam logic [9:0]  IDX_PRIO6   = 10'h006;
  localparam logic [9:0]  IDX_PENDING = 10'h010;

  // Implemented bits; reserved ranges are zero here
  localparam logic [15:0] MASK_PRIO4  = 16'hFC3F;
  localparam logic [15:0] MASK_PRIO5  = 16'hFF3F;
  localparam logic [15:0] MASK_PRIO6  = 16'hFFCF;
  localparam logic [15:0] RESET_PRIO  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Field codes
  localparam logic [1:0]  CODE_OFF    = 2'h0;
  localparam logic [1:0]  CODE_LVL0   = 2'h1;
  localparam logic [1:0]  CODE_LVL1   = 2'h2;
  localparam logic [1:0]  CODE_LVL2   = 2'h3;
  localparam logic [1:0]  LEVEL_0     = 2'h0;
  localparam logic [1:0]  LEVEL_1     = 2'h1;
  localparam logic [1:0]  LEVEL_2     = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Per-source placement: register slot (0..2 for registers 4..6) and field lsb
  localparam int SRC_REG [NUM_SRC] = '{0, 0, 0, 0, 0, 0,
                                       1, 1, 1, 1, 1, 1, 1,
                                       2, 2, 2, 2, 2, 2, 2};
  localparam int SRC_LSB [NUM_SRC] = '{14, 12, 10, 4, 2, 0,
                                       14, 12, 10, 8, 4, 2, 0,
                                       14, 12, 10, 8, 6, 2, 0};

  function automatic logic [ADDR_W-1:0] regByteAddr(input logic [9:0] idx);
    regByteAddr = {idx, 2'b00};
  endfunction : regByteAddr

  // Never yields a level above 2
  function automatic logic [1:0] fieldToLevel(input logic [1:0] code);
    unique case (code)
      CODE_LVL0: fieldToLevel = LEVEL_0;
      CODE_LVL1: fieldToLevel = LEVEL_1;
      CODE_LVL2: fieldToLevel = LEVEL_2;
      default:   fieldToLevel = LEVEL_0;
    endcase
  endfunction : fieldToLevel

  function automatic logic [REG_W-1:0] writeMerge(input logic [REG_W-1:0] old,
                                                  input logic [REG_W-1:0] wdata,
                                                  input logic [1:0]       strb,
                                                  input logic [REG_W-1:0] mask);
    logic [REG_W-1:0] lanes;
    lanes      = {{8{strb[1]}}, {8{strb[0]}}};
    writeMerge = ((old & ~lanes) | (wdata & lanes)) & mask;
  endfunction : writeMerge

endpackage : iprfs_pkg

// File: rtl/iprfs_src_gate.sv
`timescale 1ns/100ps
module iprfs_src_gate
  import iprfs_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Programmed field and raw request
  input  wire logic [1:0] fieldCode,
  input  wire logic       srcReq,
  // Forwarded request
  output logic            irqReq_q,
  output logic [1:0]      irqLevel_q
);

  logic       enabled;
  logic       irqReq_d;
  logic [1:0] irqLevel_d;

  assign enabled    = (fieldCode != CODE_OFF);
  assign irqReq_d   = srcReq & enabled;
  assign irqLevel_d = enabled ? fieldToLevel(fieldCode) : LEVEL_0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irqReq_q   <= 1'b0;
      irqLevel_q <= LEVEL_0;
    end else begin
      irqReq_q   <= irqReq_d;
      irqLevel_q <= irqLevel_d;
    end
  end

endmodule : iprfs_src_gate

// File: tb/iprfs_regs_asserts.sv
`timescale 1ns/100ps
module iprfs_regs_asserts
  import iprfs_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              nrst,
  // APB side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  // Watched sources
  input wire logic              pinPortAReq,
  input wire logic              pinPortAIrq,
  input wire logic              timerDCh0Irq,
  input wire logic [1:0]        pinPortALevel,
  input wire logic [1:0]        serialPort0RxFullLevel,
  input wire logic [1:0]        asyncIf1RxErrorLevel,
  input wire logic [1:0]        timerDCh0Level,
  input wire logic [1:0]        decoder0HomeWatchdogLevel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  wire acc = psel && penable;
  wire wr4 = acc && pwrite && paddr == 12'h010;
  wire wr5 = acc && pwrite && paddr == 12'h014;
  wire wr6 = acc && pwrite && paddr == 12'h018;

  function automatic logic [1:0] lvlOf(input logic [31:0] w, input int lsb);
    return (w[lsb +: 2] == 2'h0) ? 2'h0 : w[lsb +: 2] - 2'h1;
  endfunction : lvlOf

  ////////////////////////////////////////////////////////////////////////////
  property p_rst_off;
    $rose(nrst) |-> !pinPortAIrq && !timerDCh0Irq && pinPortALevel == 2'h0 && timerDCh0Level == 2'h0;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("request live right after reset");
  property p_lvl_cap;
    pinPortALevel != 2'h3 && timerDCh0Level != 2'h3;
  endproperty
  a_lvl_cap: assert property (p_lvl_cap) else $error("level above 2");
  property p_fwd;
    pinPortAIrq |-> $past(pinPortAReq);
  endproperty
  a_fwd: assert property (p_fwd) else $error("request forwarded without source");
  property p_mask;
    $past(pinPortAReq) && !pinPortAIrq |-> pinPortALevel == 2'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("enabled source masked");
  property p_sp0rx;
    wr4 && pstrb[1] |-> ##2 serialPort0RxFullLevel == lvlOf($past(pwdata, 2), 14);
  endproperty
  a_sp0rx: assert property (p_sp0rx) else $error("bits 15:14 of reg4 misplaced");
  property p_pina;
    wr4 && pstrb[0] |-> ##2 pinPortALevel == lvlOf($past(pwdata, 2), 4);
  endproperty
  a_pina: assert property (p_pina) else $error("bits 5:4 of reg4 misplaced");
  property p_rxerr;
    wr5 && pstrb[1] |-> ##2 asyncIf1RxErrorLevel == lvlOf($past(pwdata, 2), 8);
  endproperty
  a_rxerr: assert property (p_rxerr) else $error("bits 9:8 of reg5 misplaced");
  property p_tmrd0;
    wr6 && pstrb[0] |-> ##2 timerDCh0Level == lvlOf($past(pwdata, 2), 6);
  endproperty
  a_tmrd0: assert property (p_tmrd0) else $error("bits 7:6 of reg6 misplaced");
  property p_dec0h;
    wr6 && pstrb[0] |-> ##2 decoder0HomeWatchdogLevel == lvlOf($past(pwdata, 2), 0);
  endproperty
  a_dec0h: assert property (p_dec0h) else $error("bits 1:0 of reg6 misplaced");
  property p_rsvd;
    acc && !pwrite && paddr == 12'h010 |-> prdata[9:6] == 4'h0 && prdata[31:16] == 16'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits of reg4 not zero");
endmodule : iprfs_regs_asserts

bind iprfs_regs iprfs_regs_asserts iprfs_regs_asserts_inst (.*);

// File: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin numChecks++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
  import iprfs_pkg::*;
  logic              sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic [3:0]        pstrb = 4'hF;
  logic              pready, pslverr;
  logic [19:0]       reqV = 20'hFFFFF, r20, irqV;
  logic [39:0]       lvlV;
  logic [32:0]       expQ [$], seenExp;
  logic [15:0]       sh [3] = '{16'h0, 16'h0, 16'h0};
  logic [31:0]       seed = 32'h0000F1BB;
  int                miscompares = 0, numChecks = 0, cycles = 0;
  // Implemented bits per register; reserved ranges stay zero
  localparam logic [15:0] IMPL [3] = '{16'hFC3F, 16'hFF3F, 16'hFFCF};
  localparam int          FLD [20] = '{14, 12, 10, 4, 2, 0, 14, 12, 10, 8, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0};
  localparam logic [31:0] PAT [4] = '{32'h0, 32'hFFFF5555, 32'h0000AAAA, 32'hFFFFFFFF};
  wire serialPort0RxFullReq = reqV[0], serialPort1TxEmptyReq = reqV[1], serialPort1RxFullReq = reqV[2];
  wire pinPortAReq = reqV[3], pinPortBReq = reqV[4], pinPortCReq = reqV[5], decoder1IndexReq = reqV[6];
  wire decoder1HomeWatchdogReq = reqV[7], asyncIf1RxFullReq = reqV[8], asyncIf1RxErrorReq = reqV[9];
  wire asyncIf1TxIdleReq = reqV[10], asyncIf1TxEmptyReq = reqV[11], serialPort0TxEmptyReq = reqV[12];
  wire timerCCh0Req = reqV[13], timerDCh3Req = reqV[14], timerDCh2Req = reqV[15], timerDCh1Req = reqV[16];
  wire timerDCh0Req = reqV[17], decoder0IndexReq = reqV[18], decoder0HomeWatchdogReq = reqV[19];
  logic serialPort0RxFullIrq, serialPort1TxEmptyIrq, serialPort1RxFullIrq, pinPortAIrq, pinPortBIrq, pinPortCIrq;
  logic decoder1IndexIrq, decoder1HomeWatchdogIrq, asyncIf1RxFullIrq, asyncIf1RxErrorIrq, asyncIf1TxIdleIrq;
  logic asyncIf1TxEmptyIrq, serialPort0TxEmptyIrq, timerCCh0Irq, timerDCh3Irq, timerDCh2Irq, timerDCh1Irq;
  logic timerDCh0Irq, decoder0IndexIrq, decoder0HomeWatchdogIrq;
  logic [1:0] serialPort0RxFullLevel, serialPort1TxEmptyLevel, serialPort1RxFullLevel, pinPortALevel;
  logic [1:0] pinPortBLevel, pinPortCLevel, decoder1IndexLevel, decoder1HomeWatchdogLevel, asyncIf1RxFullLevel;
  logic [1:0] asyncIf1RxErrorLevel, asyncIf1TxIdleLevel, asyncIf1TxEmptyLevel, serialPort0TxEmptyLevel;
  logic [1:0] timerCCh0Level, timerDCh3Level, timerDCh2Level, timerDCh1Level, timerDCh0Level;
  logic [1:0] decoder0IndexLevel, decoder0HomeWatchdogLevel;
  assign lvlV = {decoder0HomeWatchdogLevel, decoder0IndexLevel, timerDCh0Level, timerDCh1Level, timerDCh2Level,
                 timerDCh3Level, timerCCh0Level, serialPort0TxEmptyLevel, asyncIf1TxEmptyLevel, asyncIf1TxIdleLevel,
                 asyncIf1RxErrorLevel, asyncIf1RxFullLevel, decoder1HomeWatchdogLevel, decoder1IndexLevel,
                 pinPortCLevel, pinPortBLevel, pinPortALevel, serialPort1RxFullLevel, serialPort1TxEmptyLevel,
                 serialPort0RxFullLevel};
  assign irqV = {decoder0HomeWatchdogIrq, decoder0IndexIrq, timerDCh0Irq, timerDCh1Irq, timerDCh2Irq, timerDCh3Irq,
                 timerCCh0Irq, serialPort0TxEmptyIrq, asyncIf1TxEmptyIrq, asyncIf1TxIdleIrq, asyncIf1RxErrorIrq,
                 asyncIf1RxFullIrq, decoder1HomeWatchdogIrq, decoder1IndexIrq, pinPortCIrq, pinPortBIrq, pinPortAIrq,
                 serialPort1RxFullIrq, serialPort1TxEmptyIrq, serialPort0RxFullIrq};

  iprfs_regs iprfs_regs_inst (.*);

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic wrapUp();
    $display("Checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrapUp

  // Each transfer notes {pslverr, prdata} expected at its access edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
                      input logic [3:0] s = 4'hF);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    pstrb   <= s;
    paddr   <= a;
    pwdata  <= d;
    expQ.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Strobe bit 0 covers bits 7:0, bit 1 bits 15:8
  task automatic regWr(input int r, input logic [31:0] d, input logic [1:0] s);
    logic [15:0] lanes;
    lanes = {{8{s[1]}}, {8{s[0]}}};
    sh[r] = ((sh[r] & ~lanes) | (d[15:0] & lanes)) & IMPL[r];
    xfer(1'b1, 12'h010 + 12'(4 * r), d, 33'h0, {2'h0, s});
  endtask : regWr

  task automatic regRd(input int r);
    xfer(1'b0, 12'h010 + 12'(4 * r), 32'h0, {17'h0, sh[r]});
  endtask : regRd

  task automatic chkSrc();
    logic [19:0] pend;
    logic [1:0]  c;
    pend = '0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    for (int i = 0; i < 20; i++) begin
      c       = sh[i < 6 ? 0 : (i < 13 ? 1 : 2)][FLD[i] +: 2];
      pend[i] = reqV[i] && c != 2'h0;
      `CHK("level", ((c == 2'h0) ? 2'h0 : c - 2'h1), lvlV[2 * i +: 2])
    end
    `CHK("irq", pend, irqV)
    xfer(1'b0, 12'h040, 32'h0, {13'h0, pend});
  endtask : chkSrc

  always @(posedge sys_clk) begin
    if (psel && penable && pready) begin
      seenExp = expQ.pop_front();
      `CHK("apb", seenExp, {pslverr, prdata})
    end
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      wrapUp();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int r = 0; r < 3; r++) regRd(r);
    chkSrc();
    $display("Test reset done");
    for (int k = 0; k < 14; k++) begin
      r20 = 20'(rnd());
      @(posedge sys_clk);
      reqV <= r20;
      for (int r = 0; r < 3; r++) regWr(r, k < 4 ? PAT[k] : rnd(), k < 8 ? 2'h3 : 2'(rnd()));
      for (int r = 0; r < 3; r++) regRd(r);
      chkSrc();
    end
    $display("Test fields done");
    // Refused places: unmapped, misaligned, read-only pending word
    xfer(1'b1, 12'h01C, 32'hFFFFFFFF, 33'h100000000);
    xfer(1'b1, 12'h011, 32'h00000000, 33'h100000000);
    xfer(1'b0, 12'h01C, 32'h00000000, 33'h100000000);
    xfer(1'b1, 12'h040, 32'h00000000, 33'h000000000);
    for (int r = 0; r < 3; r++) regRd(r);
    chkSrc();
    $display("Test refused done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    sh = '{16'h0, 16'h0, 16'h0};
    for (int r = 0; r < 3; r++) regRd(r);
    chkSrc();
    $display("Test second reset done");
    wrapUp();
  end
endmodule : tb_top
